// ===== rtl/smf_pkg.sv
// Purpose: shared types and constants for the store merge and load forwarding logic
// Assumes: 40-bit physical addresses, 64-bit store data, one core clock
// Notes:   all widths fixed; no parameters are meant to be overridden
package smf_pkg;
	localparam int PA_W         = 40;
	localparam int VA_W         = 14;
	localparam int SQ_DEPTH     = 4;
	localparam int SQ_PTR_W     = 2;
	localparam int MB_BYTES     = 16;
	localparam int MB_OFF_W     = 4;
	localparam int DW_BYTES     = 8;
	localparam int DC_SIZE_KB   = 64;
	localparam int DC_WAYS      = 4;
	localparam int DC_LINE_B    = 32;
	localparam int DC_LINE_LSB  = 5;
	localparam int DC_ALIAS_BIT = 13;
	localparam int DC_IDX_W     = DC_ALIAS_BIT + 1 - DC_LINE_LSB;
	localparam int TAG_LSB      = 13;
	localparam int VA_OVL_MSB   = 12;
	localparam int DW_LSB       = 3;
	localparam logic [7:0] ASI_PHYS_L2      = 8'h14;
	localparam logic [7:0] ASI_INT_LO_A     = 8'h30;
	localparam logic [7:0] ASI_INT_HI_A     = 8'h6f;
	localparam logic [7:0] ASI_INT_LO_B     = 8'h72;
	localparam logic [7:0] ASI_INT_HI_B     = 8'h7f;
	localparam logic [15:0] MB_BE_NONE      = 16'h0000;
	localparam logic [7:0]  BE_BYTE         = 8'h01;
	localparam logic [7:0]  BE_HALF         = 8'h03;
	localparam logic [7:0]  BE_WORD         = 8'h0f;
	localparam logic [7:0]  BE_DWORD        = 8'hff;

	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2, SZ_DWORD = 2'h3} smf_size_t;
	typedef enum logic [2:0] {
		ST_NORMAL = 3'h0, ST_FP_PARTIAL = 3'h1, ST_INT_DOUBLE = 3'h2, ST_ATOMIC = 3'h3, ST_SHORT_FP = 3'h4
	} smf_st_kind_t;
	typedef enum logic [2:0] {
		LD_NORMAL = 3'h0, LD_SIGNED = 3'h1, LD_ATOMIC = 3'h2, LD_INT_DOUBLE = 3'h3,
		LD_QUAD = 3'h4, LD_FSR = 3'h5, LD_BLOCK = 3'h6, LD_SHORT_FP = 3'h7
	} smf_ld_kind_t;
	typedef enum logic [3:0] {
		CLS_CACHE_VIRT = 4'h1, CLS_CACHE_NOVIRT = 4'h2, CLS_PCACHE = 4'h4, CLS_NONCACHE = 4'h8
	} smf_class_t;

	typedef struct packed {
		logic [PA_W-1:0] pa;
		logic [VA_W-1:0] va;
		smf_size_t       size;
		logic            little;
		smf_st_kind_t    kind;
		logic            physical_cacheable_bit;
		logic            side_effect;
		logic [63:0]     data;
	} smf_st_req_t;

	typedef struct packed {
		logic [PA_W-1:0]       pa;
		logic [VA_W-1:0]       va;
		smf_size_t             size;
		logic                  little;
		smf_ld_kind_t          kind;
		logic [7:0]            asi;
		logic                  physical_cacheable_bit;
		logic                  virtual_cacheable_bit;
		logic                  side_effect;
		logic                  tag_valid;
		logic [PA_W-1:TAG_LSB] tag;
		logic                  pcache_hit;
	} smf_ld_req_t;

	typedef struct packed {
		logic                     fwd;
		logic                     recirc;
		logic                     from_mem;
		logic                     dcache_bypass;
		logic                     dcache_hit;
		logic [DC_IDX_W-1:0]      dcache_index;
		smf_class_t               cls;
		logic [63:0]              data;
	} smf_ld_resp_t;

	typedef struct packed {
		logic [PA_W-1:MB_OFF_W]   addr;
		logic [MB_BYTES*8-1:0]    data;
		logic [MB_BYTES-1:0]      be;
	} smf_nc_wr_t;
endpackage : smf_pkg

// ===== rtl/smf_nc_merge.sv
// Purpose: sixteen-byte non-cacheable store merge buffer
// Assumes: incoming stores are already placed on their byte lanes
// Notes:   a closed buffer holds off new stores until the target pulls it
`timescale 1ns/1ns
module smf_nc_merge import smf_pkg::*; (
	input  wire logic                   mclk_in,
	input  wire logic                   reset_in,
	input  wire logic                   st_valid_in,
	input  wire logic                   st_side_effect_in,
	input  wire logic                   close_in,
	input  wire logic [PA_W-1:MB_OFF_W] st_region_in,
	input  wire logic [MB_BYTES-1:0]    st_be_in,
	input  wire logic [MB_BYTES*8-1:0]  st_data_in,
	output logic                        st_ready_out,
	input  wire logic                   take_in,
	output logic                        wr_valid_out,
	output smf_nc_wr_t                  wr_out
);
	logic [MB_BYTES-1:0]   byte_valid;
	logic [PA_W-1:MB_OFF_W] region;
	logic [MB_BYTES*8-1:0] data;
	logic                  closed;

	wire buf_empty   = (byte_valid == MB_BE_NONE);
	wire same_region = (st_region_in == region);
	wire overwrite   = |(st_be_in & byte_valid);
	// merge only into an open region, never onto a written byte, never a side-effect store
	wire can_merge   = !closed && same_region && !overwrite && !st_side_effect_in;
	wire accept      = st_valid_in && !take_in && (buf_empty || can_merge);
	wire must_close  = close_in || (st_valid_in && !buf_empty && !can_merge);

	assign st_ready_out = !take_in && (buf_empty || can_merge);
	assign wr_valid_out = !buf_empty;
	assign wr_out       = '{addr: region, data: data, be: byte_valid};

	logic [MB_BYTES*8-1:0] next_data;
	genvar b;
	generate
		for (b = 0; b < MB_BYTES; b++) begin : g_lane
			assign next_data[b*8 +: 8] = st_be_in[b] ? st_data_in[b*8 +: 8] : data[b*8 +: 8];
		end
	endgenerate

	always_ff @(posedge mclk_in) begin
		if (reset_in || take_in) begin
			byte_valid <= MB_BE_NONE;
			closed     <= 1'b0;
		end else if (accept) begin
			byte_valid <= byte_valid | st_be_in;
			closed     <= st_side_effect_in || close_in;
		end else if (must_close) begin
			closed     <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			region <= '0;
			data   <= '0;
		end else if (accept) begin
			region <= st_region_in;
			data   <= buf_empty ? st_data_in : next_data;
		end
	end
endmodule : smf_nc_merge

// ===== rtl/smf_lsu.sv
// Purpose: store queue forwarding, load hazard recirculation, nc store merging, dcache decode
// Assumes: loads and stores naturally aligned; memory system retires the oldest queued store
// Notes:   load answers are registered one cycle after the request
// Operation
// - back-to-back non-cacheable non-side-effect stores merge into aligned 16-byte entries
// - cacheable stores never merge; nc stores merge only with nc stores
// - a side-effect store is never merged with any other store
// - sixteen byte valid flags; writing a valid byte ends the merge
// - merging continues until the buffer closes or the target device pulls it
// - a store outside the current 16-byte region ends the merge
// - a cacheable store, side-effect store or sync barrier ends the merge
// - forward only on same address, endianness, size, both eligible, cache hit
// - when forwarding fails the load takes data from the memory system
// - a load matching more than one queued store is recirculated
// - recirculate when VA 12:0 overlaps a store that cannot forward
// - recirculate a dcache miss whose VA 12:5 equals any queued store
// - side-effect load recirculates while side-effect stores are queued
// - dcache is 64 KB write-through, no write allocate, pseudo 4-way, 32-byte lines
// - bypass dcache when disabled, translation and virt cacheable clear, or page not virt cacheable
// - dcache indexed by virtual bits, hit by physical tag compare
// - decode the physical and virtual cacheable bits into four classes
// - with dcache enabled a non-virt-cacheable access may still hit old data
// - physical l2 address space indexes the dcache with physical bit 13
`timescale 1ns/1ns
module smf_lsu import smf_pkg::*; (
	input  wire logic         mclk_in,
	input  wire logic         reset_in,
	input  wire logic         dcache_enable_bit_in,
	input  wire logic         data_translation_enable_bit_in,
	input  wire logic         virtual_cacheable_bit_in,
	input  wire logic         st_valid_in,
	input  smf_st_req_t       st_in,
	output logic              st_ready_out,
	input  wire logic         sq_retire_in,
	output logic [SQ_PTR_W:0] sq_count_out,
	input  wire logic         membar_sync_in,
	input  wire logic         ld_valid_in,
	input  smf_ld_req_t       ld_in,
	output logic              ld_resp_valid_out,
	output smf_ld_resp_t      ld_resp_out,
	input  wire logic         nc_take_in,
	output logic              nc_wr_valid_out,
	output smf_nc_wr_t        nc_wr_out
);
	// geometry of the data cache this logic decodes for
	localparam int DC_SETS = DC_SIZE_KB * 1024 / (DC_WAYS * DC_LINE_B);

	smf_st_req_t               sq_entry [SQ_DEPTH];
	logic [SQ_DEPTH-1:0]       sq_valid;
	logic [SQ_PTR_W-1:0]       sq_head;
	logic [SQ_PTR_W-1:0]       sq_tail;
	logic [SQ_PTR_W:0]         sq_count;

	// store side classification
	wire st_nc          = !st_in.physical_cacheable_bit;
	wire st_fwd_ok_in   = (st_in.kind == ST_NORMAL) && !st_in.side_effect && !st_nc;
	wire st_to_merge    = st_nc;
	wire sq_full        = (sq_count == (SQ_PTR_W+1)'(SQ_DEPTH));
	wire mb_ready;
	wire st_go          = st_valid_in && st_ready_out;
	wire sq_pop         = sq_retire_in && sq_valid[sq_head];

	assign st_ready_out = !sq_full && (!st_to_merge || mb_ready);
	assign sq_count_out = sq_count;

	function automatic logic [7:0] size_mask(input smf_size_t sz);
		case (sz)
			SZ_BYTE:  size_mask = BE_BYTE;
			SZ_HALF:  size_mask = BE_HALF;
			SZ_WORD:  size_mask = BE_WORD;
			SZ_DWORD: size_mask = BE_DWORD;
			default:  size_mask = BE_DWORD;
		endcase
	endfunction : size_mask

	// place the right-justified store data onto its lanes in the 16-byte region
	wire [MB_OFF_W-1:0]   st_off    = st_in.pa[MB_OFF_W-1:0];
	wire [MB_BYTES-1:0]   st_be16   = MB_BYTES'({8'h00, size_mask(st_in.size)} << st_off);
	wire [MB_BYTES*8-1:0] st_data16 = (MB_BYTES*8)'({64'h0000_0000_0000_0000, st_in.data} << {st_off, 3'b000});

	// a cacheable store or a sync barrier closes the open merge
	wire mb_close = membar_sync_in || (st_valid_in && !st_nc);

	smf_nc_merge u_merge (
		.mclk_in           (mclk_in),
		.reset_in          (reset_in),
		.st_valid_in       (st_valid_in && st_to_merge && !sq_full),
		.st_side_effect_in (st_in.side_effect),
		.close_in          (mb_close),
		.st_region_in      (st_in.pa[PA_W-1:MB_OFF_W]),
		.st_be_in          (st_be16),
		.st_data_in        (st_data16),
		.st_ready_out      (mb_ready),
		.take_in           (nc_take_in),
		.wr_valid_out      (nc_wr_valid_out),
		.wr_out            (nc_wr_out)
	);

	// store queue fill and drain; forwarding eligibility is kept per entry
	logic [SQ_DEPTH-1:0] sq_fwd_ok;
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			sq_head  <= '0;
			sq_tail  <= '0;
			sq_count <= '0;
		end else begin
			sq_head  <= sq_head + SQ_PTR_W'(sq_pop);
			sq_tail  <= sq_tail + SQ_PTR_W'(st_go);
			sq_count <= sq_count + (SQ_PTR_W+1)'(st_go) - (SQ_PTR_W+1)'(sq_pop);
		end
	end

	genvar e;
	generate
		for (e = 0; e < SQ_DEPTH; e++) begin : g_sq
			wire wr_here  = st_go && (sq_tail == SQ_PTR_W'(e));
			wire pop_here = sq_pop && (sq_head == SQ_PTR_W'(e));
			always_ff @(posedge mclk_in) begin
				if (reset_in) begin
					sq_valid[e]  <= 1'b0;
					sq_fwd_ok[e] <= 1'b0;
					sq_entry[e]  <= '0;
				end else if (wr_here) begin
					sq_valid[e]  <= 1'b1;
					sq_fwd_ok[e] <= st_fwd_ok_in;
					sq_entry[e]  <= st_in;
				end else if (pop_here) begin
					sq_valid[e]  <= 1'b0;
				end
			end
		end
	endgenerate

	// load side classification
	wire ld_internal = ((ld_in.asi >= ASI_INT_LO_A) && (ld_in.asi <= ASI_INT_HI_A))
	                 || ((ld_in.asi >= ASI_INT_LO_B) && (ld_in.asi <= ASI_INT_HI_B));
	wire ld_fwd_ok   = (ld_in.kind == LD_NORMAL) && !ld_internal;
	wire [7:0] ld_be = size_mask(ld_in.size) << ld_in.va[DW_LSB-1:0];

	// dcache lookup: virtual index, physical tag
	wire phys_l2     = (ld_in.asi == ASI_PHYS_L2);
	wire idx_bit13   = phys_l2 ? ld_in.pa[DC_ALIAS_BIT] : ld_in.va[DC_ALIAS_BIT];
	wire [DC_IDX_W-1:0] dc_index = {idx_bit13, ld_in.va[DC_ALIAS_BIT-1:DC_LINE_LSB]};
	// a hit is honoured on tag match alone while enabled, so stale lines can still answer
	wire dc_hit      = dcache_enable_bit_in && ld_in.tag_valid
	                 && (ld_in.tag == ld_in.pa[PA_W-1:TAG_LSB]);
	wire dc_bypass   = !dcache_enable_bit_in
	                 || (!data_translation_enable_bit_in && !virtual_cacheable_bit_in)
	                 || !ld_in.virtual_cacheable_bit;
	wire ld_cache_hit = dc_hit || ld_in.pcache_hit;

	smf_class_t ld_cls;
	always_comb begin
		case ({ld_in.physical_cacheable_bit, ld_in.virtual_cacheable_bit})
			2'b11:   ld_cls = CLS_CACHE_VIRT;
			2'b10:   ld_cls = CLS_CACHE_NOVIRT;
			2'b01:   ld_cls = CLS_PCACHE;
			default: ld_cls = CLS_NONCACHE;
		endcase
	end

	// per-entry comparisons against the incoming load
	logic [SQ_DEPTH-1:0] exact;
	logic [SQ_DEPTH-1:0] overlap;
	logic [SQ_DEPTH-1:0] line_eq;
	logic [SQ_DEPTH-1:0] se_q;
	generate
		for (e = 0; e < SQ_DEPTH; e++) begin : g_cmp
			wire [7:0] sbe = size_mask(sq_entry[e].size) << sq_entry[e].va[DW_LSB-1:0];
			assign exact[e]   = sq_valid[e] && (sq_entry[e].pa == ld_in.pa)
			                  && (sq_entry[e].little == ld_in.little)
			                  && (sq_entry[e].size == ld_in.size);
			assign overlap[e] = sq_valid[e]
			                  && (sq_entry[e].va[VA_OVL_MSB:DW_LSB] == ld_in.va[VA_OVL_MSB:DW_LSB])
			                  && |(sbe & ld_be);
			assign line_eq[e] = sq_valid[e]
			                  && (sq_entry[e].va[VA_OVL_MSB:DC_LINE_LSB] == ld_in.va[VA_OVL_MSB:DC_LINE_LSB]);
			assign se_q[e]    = sq_valid[e] && sq_entry[e].side_effect;
		end
	endgenerate

	wire [SQ_DEPTH-1:0] fwd_cand = exact & sq_fwd_ok & {SQ_DEPTH{ld_fwd_ok}};
	// overlapping stores that cannot give their data to this load
	wire [SQ_DEPTH-1:0] blocked  = overlap & ~fwd_cand;

	logic [SQ_PTR_W:0] n_cand;
	logic [63:0]       cand_data;
	always_comb begin
		n_cand    = '0;
		cand_data = '0;
		for (int i = 0; i < SQ_DEPTH; i++) begin
			n_cand = n_cand + (SQ_PTR_W+1)'(fwd_cand[i]);
			if (fwd_cand[i]) begin
				cand_data = sq_entry[i].data;
			end
		end
	end

	wire multi     = (n_cand > (SQ_PTR_W+1)'(1));
	wire recirc    = multi || (|blocked)
	               || (!dc_hit && (|line_eq))
	               || (ld_in.side_effect && (|se_q));
	wire fwd       = !recirc && (n_cand == (SQ_PTR_W+1)'(1)) && ld_cache_hit;
	wire from_mem  = !recirc && !fwd;

	smf_ld_resp_t next_resp;
	assign next_resp = '{
		fwd:           fwd,
		recirc:        recirc,
		from_mem:      from_mem,
		dcache_bypass: dc_bypass,
		dcache_hit:    dc_hit,
		dcache_index:  dc_index,
		cls:           ld_cls,
		data:          fwd ? cand_data : 64'h0000_0000_0000_0000
	};

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			ld_resp_valid_out <= 1'b0;
			ld_resp_out       <= '{cls: CLS_NONCACHE, default: '0};
		end else begin
			ld_resp_valid_out <= ld_valid_in;
			if (ld_valid_in) begin
				ld_resp_out <= next_resp;
			end
		end
	end
endmodule : smf_lsu

// ===== test/smf_lsu_props.sv
// Purpose: port-level assertions for the load/store forwarding block
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every smf_lsu instance
`timescale 1ns/1ns
module smf_lsu_props import smf_pkg::*; (
	input wire logic          mclk_in,
	input wire logic          reset_in,
	input wire logic          dcache_enable_bit_in,
	input wire logic          st_valid_in,
	input smf_st_req_t        st_in,
	input wire logic          st_ready_out,
	input wire logic          ld_valid_in,
	input smf_ld_req_t        ld_in,
	input wire logic          ld_resp_valid_out,
	input smf_ld_resp_t       ld_resp_out,
	input wire logic          nc_take_in,
	input wire logic          nc_wr_valid_out,
	input smf_nc_wr_t         nc_wr_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	logic [DC_IDX_W-1:0] idx_q;
	wire logic dc_hit = dcache_enable_bit_in & ld_in.tag_valid & (ld_in.tag == ld_in.pa[PA_W-1:TAG_LSB]);
	wire logic nc_offer = st_valid_in & ~st_in.physical_cacheable_bit;
	always_ff @(posedge mclk_in) begin
		idx_q <= {ld_in.pa[DC_ALIAS_BIT], ld_in.va[12:5]};
	end
	one_outcome_a: assert property (ld_resp_valid_out |-> $onehot({ld_resp_out.fwd, ld_resp_out.recirc,
		ld_resp_out.from_mem})) else $error("load outcome not unique");
	cls_virt_a: assert property (ld_valid_in && ld_in.physical_cacheable_bit && ld_in.virtual_cacheable_bit
		|=> ld_resp_out.cls == CLS_CACHE_VIRT) else $error("class decode wrong");
	index_phys_a: assert property (ld_valid_in && ld_in.asi == ASI_PHYS_L2
		|=> ld_resp_out.dcache_index == idx_q) else $error("physical index wrong");
	bypass_off_a: assert property (ld_valid_in && !dcache_enable_bit_in
		|=> ld_resp_out.dcache_bypass && !ld_resp_out.dcache_hit) else $error("disabled cache not bypassed");
	kind_nofwd_a: assert property (ld_valid_in && ld_in.kind != LD_NORMAL |=> !ld_resp_out.fwd)
		else $error("ineligible load forwarded");
	hit_needed_a: assert property (ld_valid_in && !ld_in.pcache_hit && !dc_hit |=> !ld_resp_out.fwd)
		else $error("forward without cache hit");
	take_clears_a: assert property (nc_take_in |=> !nc_wr_valid_out)
		else $error("buffer not cleared on take");
	se_alone_a: assert property (nc_offer && st_in.side_effect && st_ready_out && !nc_take_in
		|=> !(nc_offer && st_ready_out)) else $error("side-effect store merged");
	be_keep_a: assert property (nc_wr_valid_out && !nc_take_in
		|=> (nc_wr_out.be & $past(nc_wr_out.be)) == $past(nc_wr_out.be)) else $error("byte flag lost");
	region_keep_a: assert property (nc_wr_valid_out && !nc_take_in
		|=> nc_wr_out.addr == $past(nc_wr_out.addr)) else $error("merge region moved");
	cover property (ld_resp_valid_out && ld_resp_out.fwd);
	cover property (ld_resp_valid_out && ld_resp_out.recirc);
	cover property (nc_take_in && nc_wr_valid_out);
endmodule : smf_lsu_props
bind smf_lsu smf_lsu_props props_i (.mclk_in(mclk_in), .reset_in(reset_in),
	.dcache_enable_bit_in(dcache_enable_bit_in), .st_valid_in(st_valid_in), .st_in(st_in),
	.st_ready_out(st_ready_out), .ld_valid_in(ld_valid_in), .ld_in(ld_in), .ld_resp_valid_out(ld_resp_valid_out),
	.ld_resp_out(ld_resp_out), .nc_take_in(nc_take_in), .nc_wr_valid_out(nc_wr_valid_out), .nc_wr_out(nc_wr_out));

// ===== test/smf_tgt_model.sv
// Purpose: target device that pulls the non-cacheable merge buffer
// Assumes: pulls one cycle after the buffer shows data unless stalled
// Notes:   keeps the last pulled write for the bench
`timescale 1ns/1ns
module smf_tgt_model import smf_pkg::*; (
	input  wire logic  mclk_in,
	input  wire logic  reset_in,
	input  wire logic  stall_in,
	input  wire logic  wr_valid_in,
	input  smf_nc_wr_t wr_in,
	output logic       take_out,
	output smf_nc_wr_t last_out
);
	// no back-to-back pulls: the buffer clears at the pulling edge
	wire logic pull = wr_valid_in & ~stall_in & ~take_out;
	always_ff @(posedge mclk_in) begin
		take_out <= ~reset_in & pull;
		if (take_out)
			last_out <= wr_in;
	end
endmodule : smf_tgt_model

// ===== test/smf_lsu_tb.sv
// Purpose: self-checking bench for store merging and load forwarding
// Assumes: target model pulls the merge buffer when not stalled
// Notes:   stores and loads go one at a time with an idle cycle between
`timescale 1ns/1ns
module smf_lsu_tb import smf_pkg::*;;
	logic clk, rst, dc_en, dte, cvb, st_valid, retire, membar, ld_valid, stall;
	smf_st_req_t st, sv;
	smf_ld_req_t ld, q;
	smf_ld_resp_t resp, r;
	smf_nc_wr_t ncw, last;
	wire logic st_ready, ld_rv, nc_wv, take;
	wire logic [SQ_PTR_W:0] sqc;
	int fail_count, cmp_count;
	smf_lsu dut (.mclk_in(clk), .reset_in(rst), .dcache_enable_bit_in(dc_en),
		.data_translation_enable_bit_in(dte), .virtual_cacheable_bit_in(cvb), .st_valid_in(st_valid),
		.st_in(st), .st_ready_out(st_ready), .sq_retire_in(retire), .sq_count_out(sqc),
		.membar_sync_in(membar), .ld_valid_in(ld_valid), .ld_in(ld), .ld_resp_valid_out(ld_rv),
		.ld_resp_out(resp), .nc_take_in(take), .nc_wr_valid_out(nc_wv), .nc_wr_out(ncw));
	smf_tgt_model tgt (.mclk_in(clk), .reset_in(rst), .stall_in(stall), .wr_valid_in(nc_wv),
		.wr_in(ncw), .take_out(take), .last_out(last));
	task close_out;
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic smf_st_req_t mk_st(input logic [PA_W-1:0] pa, input smf_size_t sz, input logic pc, se,
		input logic [63:0] d);
		smf_st_req_t s;
		s = '0;
		s.pa = pa;
		s.va = pa[VA_W-1:0];
		s.size = sz;
		s.physical_cacheable_bit = pc;
		s.side_effect = se;
		s.data = d;
		return s;
	endfunction : mk_st
	function automatic smf_ld_req_t mk_ld(input logic [PA_W-1:0] pa, input smf_size_t sz);
		smf_ld_req_t l;
		l = '0;
		l.pa = pa;
		l.va = pa[VA_W-1:0];
		l.size = sz;
		l.physical_cacheable_bit = 1'b1;
		l.virtual_cacheable_bit = 1'b1;
		l.tag_valid = 1'b1;
		l.tag = pa[PA_W-1:TAG_LSB];
		return l;
	endfunction : mk_ld
	// ok low means the store is expected to be refused and is withdrawn
	task st_do(input smf_st_req_t s, input logic ok);
		int n;
		n = 0;
		@(posedge clk);
		st <= s;
		st_valid <= 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (ok && st_ready !== 1'b1 && n < 50);
		chk(st_ready, ok);
		@(posedge clk);
		st_valid <= 1'b0;
		// let the taking edge settle before anyone looks at registered outputs
		@(negedge clk);
	endtask : st_do
	task ld_do(input smf_ld_req_t l);
		@(posedge clk);
		ld <= l;
		ld_valid <= 1'b1;
		@(posedge clk);
		ld_valid <= 1'b0;
		@(negedge clk);
		chk(ld_rv, 1'b1);
		r = resp;
	endtask : ld_do
	task drain;
		@(posedge clk);
		retire <= 1'b1;
		repeat (5) @(posedge clk);
		retire <= 1'b0;
	endtask : drain
	task set_stall(input logic v);
		@(posedge clk);
		stall <= v;
		repeat (3) @(posedge clk);
	endtask : set_stall
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		fail_count++;
		close_out;
	end
	initial begin
		{rst, dc_en, dte, cvb} <= 4'hf;
		{st_valid, retire, membar, ld_valid, stall} <= 5'h00;
		st <= '0;
		ld <= '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({sqc, nc_wv, ld_rv}, 5'h00);
		set_stall(1'b1);
		st_do(mk_st(40'h0000_1000, SZ_BYTE, 1'b0, 1'b0, 64'h00a5), 1'b1);
		st_do(mk_st(40'h0000_1003, SZ_BYTE, 1'b0, 1'b0, 64'h003c), 1'b1);
		chk(ncw.be, 16'h0009);
		set_stall(1'b0);
		chk({last.addr, last.be, last.data[31:24], last.data[7:0]}, {36'h100, 16'h0009, 16'h3ca5});
		chk(nc_wv, 1'b0);
		drain;
		for (int c = 0; c < 5; c++) begin
			set_stall(1'b1);
			st_do(mk_st(40'h0000_2000, SZ_BYTE, 1'b0, c == 3, 64'h005a), 1'b1);
			case (c)
				0: st_do(mk_st(40'h0000_2000, SZ_BYTE, 1'b0, 1'b0, 64'h0011), 1'b0);
				1: st_do(mk_st(40'h0000_2010, SZ_BYTE, 1'b0, 1'b0, 64'h0011), 1'b0);
				2: begin
					@(posedge clk);
					membar <= 1'b1;
					@(posedge clk);
					membar <= 1'b0;
				end
				3: ;
				default: st_do(mk_st(40'h0000_8000, SZ_BYTE, 1'b1, 1'b0, 64'h0011), 1'b1);
			endcase
			st_do(mk_st(40'h0000_2001, SZ_BYTE, 1'b0, 1'b0, 64'h0077), 1'b0);
			if (c == 3) begin
				q = mk_ld(40'h0000_9000, SZ_BYTE);
				q.side_effect = 1'b1;
				ld_do(q);
				chk(r.recirc, 1'b1);
			end
			set_stall(1'b0);
			chk({last.be, last.data[7:0]}, {16'h0001, 8'h5a});
			drain;
		end
		st_do(mk_st(40'h0000_5008, SZ_WORD, 1'b1, 1'b0, 64'hdead_beef), 1'b1);
		q = mk_ld(40'h0000_5008, SZ_WORD);
		ld_do(q);
		chk({r.fwd, r.recirc, r.from_mem, r.data}, {3'b100, 64'hdead_beef});
		for (int k = 1; k < 8; k++) begin
			q.kind = smf_ld_kind_t'(k);
			ld_do(q);
			chk(r.fwd, 1'b0);
		end
		q = mk_ld(40'h0000_5008, SZ_BYTE);
		ld_do(q);
		chk(r.fwd, 1'b0);
		q = mk_ld(40'h0000_5008, SZ_WORD);
		q.asi = 8'h30;
		ld_do(q);
		chk(r.fwd, 1'b0);
		q.asi = 8'h00;
		q.tag_valid = 1'b0;
		ld_do(q);
		chk(r.recirc, 1'b1);
		ld_do(mk_ld(40'h0000_6100, SZ_WORD));
		chk({r.fwd, r.recirc, r.from_mem}, 3'b001);
		st_do(mk_st(40'h0000_5008, SZ_WORD, 1'b1, 1'b0, 64'h1234_5678), 1'b1);
		ld_do(mk_ld(40'h0000_5008, SZ_WORD));
		chk(r.recirc, 1'b1);
		drain;
		sv = mk_st(40'h0000_5010, SZ_DWORD, 1'b1, 1'b0, 64'h0042);
		sv.kind = ST_INT_DOUBLE;
		st_do(sv, 1'b1);
		ld_do(mk_ld(40'h0000_5010, SZ_DWORD));
		chk({r.fwd, r.recirc}, 2'b01);
		drain;
		for (int k = 0; k < 4; k++) begin
			q = mk_ld(40'h0000_a000, SZ_BYTE);
			q.physical_cacheable_bit = k[1];
			q.virtual_cacheable_bit = k[0];
			ld_do(q);
			chk({r.cls, r.dcache_bypass}, {4'h8 >> k, ~k[0]});
		end
		q = mk_ld(40'h0000_2040, SZ_BYTE);
		q.va = 14'h0040;
		ld_do(q);
		chk({r.dcache_index, r.dcache_hit}, {9'h002, 1'b1});
		q.asi = ASI_PHYS_L2;
		ld_do(q);
		chk(r.dcache_index, 9'h102);
		q.pa = 40'h0000_0040;
		q.tag = q.pa[PA_W-1:TAG_LSB];
		ld_do(q);
		chk(r.dcache_index, 9'h002);
		@(posedge clk);
		dc_en <= 1'b0;
		ld_do(q);
		chk({r.dcache_bypass, r.dcache_hit}, 2'b10);
		@(posedge clk);
		{dc_en, dte, cvb} <= 3'b100;
		ld_do(mk_ld(40'h0000_a000, SZ_BYTE));
		chk(r.dcache_bypass, 1'b1);
		close_out;
	end
endmodule : smf_lsu_tb
